/* design/pco_cross.sv */
// Crossing detector for one comparison point
`timescale 1ns/100ps
`default_nettype none
module pco_cross (
  input  wire logic        [2:0]  attr,
  input  wire logic               level_form,
  input  wire logic signed [31:0] prev_pos,
  input  wire logic signed [31:0] cur_pos,
  input  wire logic signed [31:0] tgt_pos,
  output logic                    hit,
  output logic                    skip,
  output logic                    drive_active
);
  import pco_pkg::*;

  wire       fwd_cross = (prev_pos < tgt_pos) && (cur_pos >= tgt_pos);
  wire       bwd_cross = (prev_pos > tgt_pos) && (cur_pos <= tgt_pos);
  wire       ini_attr  = (attr >= ATTR_INI_FWD) && (attr <= ATTR_INI_BOTH);
  wire [2:0] dir_code  = ini_attr ? attr - 3'h3 : attr;
  wire       want_fwd  = (dir_code == ATTR_FWD) || (dir_code == ATTR_BOTH);
  wire       want_bwd  = (dir_code == ATTR_BWD) || (dir_code == ATTR_BOTH);

  // Codes 4 to 6 only mean something in level form
  assign skip         = (attr == ATTR_SKIP) || (attr > ATTR_INI_BOTH)
                        || (ini_attr && !level_form);
  assign hit          = !skip && ((want_fwd && fwd_cross) || (want_bwd && bwd_cross));
  assign drive_active = !ini_attr;
endmodule : pco_cross
`default_nettype wire

/* design/pco_position_compare_output.sv */
// Position compare output unit with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
module pco_position_compare_output #(
  parameter int unsigned CYC_PER_100US = pco_pkg::CYC_PER_100US_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] live_position,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             compare_out,
  output logic [15:0]      compare_pin_assign
);
  import pco_pkg::*;

  // Bus side state
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_got_r, w_got_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [11:0] waddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;

  // Software settings
  logic        ctrl_en_r;
  logic [3:0]  res_r;
  logic [1:0]  mode_r;
  logic        pol_r, form_r;
  logic [13:0] width_r;
  logic [7:0]  delay_r;
  logic [31:0] offset_r;
  logic [4:0]  first_r, last_r;
  logic [15:0] pin_r;
  logic [2:0]  attr_r [NPTS];
  logic [31:0] tgt_r  [NPTS];

  // Compare engine state
  pco_state_t  st_r, st_nxt;
  pco_cfg_t    cfg_r, cfg_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic [27:0] cnt_r, cnt_nxt;
  logic        out_r, out_nxt, pend_r, pend_nxt, en_d_r;
  logic [31:0] ref_r, ref_nxt, org_base_r, prev_r;
  logic signed [31:0] scaled_pos, cur_pos, tgt_eff;

  // Register read view: bit 32 flags a mapped address
  function automatic logic [32:0] reg_word(input logic [11:0] a);
    logic [9:0] ai;
    logic [9:0] ti;
    ai = a[11:2] - ATTR_WIDX;
    ti = a[11:2] - TGT_WIDX;
    reg_word = {1'b1, 32'h0000_0000};
    case (a)
      OFF_CTRL:  reg_word[0]     = ctrl_en_r;
      OFF_RES:   reg_word[3:0]   = res_r;
      OFF_MODE:  reg_word[1:0]   = mode_r;
      OFF_POL:   reg_word[0]     = pol_r;
      OFF_FORM:  reg_word[0]     = form_r;
      OFF_WIDTH: reg_word[13:0]  = width_r;
      OFF_DELAY: reg_word[7:0]   = delay_r;
      OFF_ORG:   reg_word[31:0]  = offset_r;
      OFF_FIRST: reg_word[4:0]   = first_r;
      OFF_LAST:  reg_word[4:0]   = last_r;
      OFF_PIN:   reg_word[15:0]  = pin_r;
      OFF_STAT:  reg_word[31:0]  = {19'h0, idx_r, 3'h0, out_r, 1'b0, st_r};
      OFF_POS:   reg_word[31:0]  = cur_pos;
      default: begin
        if (a[1:0] == 2'h0 && ai < 10'(NPTS)) begin
          reg_word[2:0] = attr_r[ai[4:0]];
        end else if (a[1:0] == 2'h0 && ti < 10'(NPTS)) begin
          reg_word[31:0] = tgt_r[ti[4:0]];
        end else begin
          reg_word = 33'h0_0000_0000;
        end
      end
    endcase
  endfunction : reg_word

  // Position pipeline; native input is 2^24 counts per revolution
  assign scaled_pos = $signed(live_position) >>> cfg_r.res;
  assign cur_pos    = scaled_pos - $signed(org_base_r) + $signed(offset_r);
  assign tgt_eff    = cfg_r.inc ? $signed(ref_r) + $signed(tgt_r[idx_r])
                                : $signed(tgt_r[idx_r]);

  // Write channel acceptance: address and data in either order
  wire        aw_hs     = s_axi_awvalid & awready_r;
  wire        w_hs      = s_axi_wvalid & wready_r;
  wire        do_wr     = aw_got_r & w_got_r & ~bvalid_r;
  wire        b_done    = bvalid_r & s_axi_bready;
  wire        aw_got_nx = (aw_got_r | aw_hs) & ~do_wr;
  wire        w_got_nx  = (w_got_r | w_hs) & ~do_wr;
  wire        bvalid_nx = do_wr | (bvalid_r & ~b_done);
  wire        ar_hs     = s_axi_arvalid & arready_r;
  wire        rvalid_nx = ar_hs | (rvalid_r & ~s_axi_rready);

  // Byte-lane merge of the incoming word over the current contents
  logic [32:0] wr_view, rd_view;  // Processes, so register updates reach the views
  always_comb wr_view = reg_word(waddr_r);
  wire [31:0] wr_mask  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wv       = (wr_view[31:0] & ~wr_mask) | (wdata_r & wr_mask);
  wire        wr_ok    = do_wr & wr_view[32];
  always_comb rd_view = reg_word(s_axi_araddr);
  wire [9:0]  w_aidx   = waddr_r[11:2] - ATTR_WIDX;
  wire [9:0]  w_tidx   = waddr_r[11:2] - TGT_WIDX;
  wire        wr_org   = wr_ok & (waddr_r == OFF_CTRL) & wv[CTRL_ORG_BIT];

  // Clamped field values; out-of-range writes saturate so indices stay legal
  wire [3:0]  res_w    = (wv > 32'(RES_MAX)) ? RES_MAX : wv[3:0];
  wire [13:0] width_w  = (wv == 32'h0) ? 14'h0001 :
                         (wv > 32'(WIDTH_MAX)) ? WIDTH_MAX : wv[13:0];
  wire [7:0]  delay_w  = (wv > 32'(DELAY_MAX)) ? DELAY_MAX : wv[7:0];
  wire [4:0]  first_w  = (wv == 32'h0) ? 5'h01 : (wv > 32'(IDX_MAX)) ? IDX_MAX : wv[4:0];
  wire [4:0]  last_w   = (wv == 32'h0) ? 5'h01 : (wv > 32'(IDX_MAX)) ? IDX_MAX : wv[4:0];

  // Bus handshake registers; ready flags come from flops so they lag by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
    end else begin
      aw_got_r  <= aw_got_nx;
      w_got_r   <= w_got_nx;
      bvalid_r  <= bvalid_nx;
      awready_r <= ~aw_got_nx & ~bvalid_nx;
      wready_r  <= ~w_got_nx & ~bvalid_nx;
      rvalid_r  <= rvalid_nx;
      arready_r <= ~rvalid_nx;
    end
  end

  // Bus payload capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (aw_hs) waddr_r <= s_axi_awaddr;
      if (w_hs) wdata_r <= s_axi_wdata;
      if (w_hs) wstrb_r <= s_axi_wstrb;
      if (do_wr) bresp_r <= wr_view[32] ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs) rdata_r <= rd_view[31:0];
      if (ar_hs) rresp_r <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Scalar settings; status and position words are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_r <= 1'b0;
      res_r     <= RES_RST;
      mode_r    <= 2'h0;
      pol_r     <= 1'b0;
      form_r    <= 1'b0;
      width_r   <= WIDTH_RST;
      delay_r   <= DELAY_RST;
      offset_r  <= 32'h0000_0000;
      first_r   <= FIRST_RST;
      last_r    <= LAST_RST;
      pin_r     <= PIN_RST;
    end else if (wr_ok) begin
      case (waddr_r)
        OFF_CTRL:  ctrl_en_r <= wv[CTRL_EN_BIT];
        OFF_RES:   res_r     <= res_w;
        OFF_MODE:  mode_r    <= wv[1:0];
        OFF_POL:   pol_r     <= wv[0];
        OFF_FORM:  form_r    <= wv[0];
        OFF_WIDTH: width_r   <= width_w;
        OFF_DELAY: delay_r   <= delay_w;
        OFF_ORG:   offset_r  <= wv;
        OFF_FIRST: first_r   <= first_w;
        OFF_LAST:  last_r    <= last_w;
        OFF_PIN:   pin_r     <= wv[15:0];
        default:   ;
      endcase
    end
  end

  // Point storage, one attribute and one target per entry
  genvar gi;
  generate
    for (gi = 0; gi < NPTS; gi++) begin : g_pt
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          attr_r[gi] <= ATTR_SKIP;
          tgt_r[gi]  <= 32'h0000_0000;
        end else begin
          if (wr_ok && w_aidx == 10'(gi)) attr_r[gi] <= wv[2:0];
          if (wr_ok && w_tidx == 10'(gi)) tgt_r[gi]  <= wv;
        end
      end
    end
  endgenerate

  // Crossing test for the point under watch
  logic pt_hit, pt_skip, pt_active;
  pco_cross u_cross (
    .attr         (attr_r[idx_r]),
    .level_form   (cfg_r.form),
    .prev_pos     ($signed(prev_r)),
    .cur_pos      (cur_pos),
    .tgt_pos      (tgt_eff),
    .hit          (pt_hit),
    .skip         (pt_skip),
    .drive_active (pt_active)
  );

  wire        en_rise   = ctrl_en_r & ~en_d_r;
  wire        at_last   = (idx_r >= last_r - 5'h01) || (idx_r == IDX_MAX - 5'h01);
  wire        hit_level = pt_active ? ~cfg_r.pol : cfg_r.pol;
  wire [27:0] width_cyc = 28'(width_r * CYC_PER_100US) - 28'h1;
  wire [27:0] delay_cyc = 28'(delay_r * CYC_PER_US) - 28'h1;

  // Compare engine next state
  always_comb begin
    logic go_apply;
    logic go_adv;
    logic lvl;
    go_apply = 1'b0;
    go_adv   = 1'b0;
    lvl      = pend_r;
    st_nxt   = st_r;
    cfg_nxt  = cfg_r;
    idx_nxt  = idx_r;
    cnt_nxt  = cnt_r;
    out_nxt  = out_r;
    ref_nxt  = ref_r;
    pend_nxt = pend_r;
    if (!ctrl_en_r) begin
      st_nxt  = ST_OFF;
      out_nxt = cfg_r.pol;
    end else if (en_rise) begin
      // Restart-time settings are taken only here
      cfg_nxt = '{res: res_r, inc: mode_r[MODE_INC_BIT], cyc: mode_r[MODE_CYC_BIT],
                  pol: pol_r, form: form_r, pin: pin_r};
      st_nxt  = ST_CMP;
      idx_nxt = first_r - 5'h01;
      ref_nxt = cur_pos;
      out_nxt = pol_r;
    end else begin
      case (st_r)
        ST_CMP: begin
          if (pt_skip) begin
            go_adv = 1'b1;
          end else if (pt_hit) begin
            ref_nxt  = tgt_eff;
            pend_nxt = hit_level;
            lvl      = hit_level;
            if (delay_r != 8'h00) begin
              cnt_nxt = delay_cyc;
              st_nxt  = ST_DELAY;
            end else begin
              go_apply = 1'b1;
            end
          end
        end
        ST_DELAY: begin
          if (cnt_r == 28'h0) go_apply = 1'b1;
          else cnt_nxt = cnt_r - 28'h1;
        end
        ST_PULSE: begin
          if (cnt_r == 28'h0) begin
            out_nxt = cfg_r.pol;
            go_adv  = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 28'h1;
          end
        end
        ST_OFF, ST_DONE: ;
        default: st_nxt = ST_OFF;
      endcase
      if (go_apply) begin
        out_nxt = lvl;
        if (!cfg_r.form) begin
          cnt_nxt = width_cyc;
          st_nxt  = ST_PULSE;
        end else begin
          go_adv = 1'b1;
        end
      end
      if (go_adv) begin
        if (!at_last) begin
          idx_nxt = idx_r + 5'h01;
          st_nxt  = ST_CMP;
        end else if (cfg_r.cyc) begin
          idx_nxt = first_r - 5'h01;
          st_nxt  = ST_CMP;
        end else begin
          st_nxt  = ST_DONE;
        end
      end
    end
  end

  // Engine registers; origin set reseeds the previous sample to avoid a false crossing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= ST_OFF;
      cfg_r      <= CFG_RST;
      idx_r      <= 5'h00;
      cnt_r      <= 28'h0;
      out_r      <= 1'b0;
      pend_r     <= 1'b0;
      ref_r      <= 32'h0000_0000;
      en_d_r     <= 1'b0;
      org_base_r <= 32'h0000_0000;
      prev_r     <= 32'h0000_0000;
    end else begin
      st_r       <= st_nxt;
      cfg_r      <= cfg_nxt;
      idx_r      <= idx_nxt;
      cnt_r      <= cnt_nxt;
      out_r      <= out_nxt;
      pend_r     <= pend_nxt;
      ref_r      <= ref_nxt;
      en_d_r     <= ctrl_en_r;
      org_base_r <= wr_org ? scaled_pos : org_base_r;
      prev_r     <= wr_org ? offset_r : cur_pos;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready      = awready_r;
  assign s_axi_wready       = wready_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_arready      = arready_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rdata        = rdata_r;
  assign s_axi_rresp        = rresp_r;
  assign compare_out        = out_r;
  assign compare_pin_assign = cfg_r.pin;
endmodule : pco_position_compare_output
`default_nettype wire

/* include/pco_pkg.sv */
// Shared constants, register map and types for the position compare output block
package pco_pkg;

  // Geometry
  localparam int          NPTS      = 20;
  localparam int          ADDR_W    = 12;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_RES   = 12'h004;
  localparam logic [11:0] OFF_MODE  = 12'h008;
  localparam logic [11:0] OFF_POL   = 12'h00C;
  localparam logic [11:0] OFF_FORM  = 12'h010;
  localparam logic [11:0] OFF_WIDTH = 12'h014;
  localparam logic [11:0] OFF_DELAY = 12'h018;
  localparam logic [11:0] OFF_ORG   = 12'h01C;
  localparam logic [11:0] OFF_FIRST = 12'h020;
  localparam logic [11:0] OFF_LAST  = 12'h024;
  localparam logic [11:0] OFF_PIN   = 12'h028;
  localparam logic [11:0] OFF_STAT  = 12'h02C;
  localparam logic [11:0] OFF_POS   = 12'h030;
  localparam logic [9:0]  ATTR_WIDX = 10'h010;  // Word index of point attribute 1
  localparam logic [9:0]  TGT_WIDX  = 10'h030;  // Word index of point target 1

  // Field positions
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_ORG_BIT = 1;
  localparam int          MODE_INC_BIT = 0;
  localparam int          MODE_CYC_BIT = 1;

  // Reset values and limits
  localparam logic [3:0]  RES_RST   = 4'h7;
  localparam logic [3:0]  RES_MAX   = 4'hA;
  localparam logic [13:0] WIDTH_RST = 14'h0064;
  localparam logic [13:0] WIDTH_MAX = 14'h2710;
  localparam logic [7:0]  DELAY_RST = 8'h00;
  localparam logic [7:0]  DELAY_MAX = 8'hC8;
  localparam logic [4:0]  FIRST_RST = 5'h01;
  localparam logic [4:0]  LAST_RST  = 5'h08;
  localparam logic [4:0]  IDX_MAX   = 5'h14;
  localparam logic [15:0] PIN_RST   = 16'h0010;

  // Timing
  localparam int CLK_PERIOD_NS     = 5;
  localparam int PULSE_UNIT_NS     = 100000;
  localparam int DELAY_UNIT_NS     = 1000;
  localparam int CYC_PER_US        = DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_100US_DEF = PULSE_UNIT_NS / CLK_PERIOD_NS;

  // Point attribute codes
  localparam logic [2:0]  ATTR_SKIP     = 3'h0;
  localparam logic [2:0]  ATTR_FWD      = 3'h1;
  localparam logic [2:0]  ATTR_BWD      = 3'h2;
  localparam logic [2:0]  ATTR_BOTH     = 3'h3;
  localparam logic [2:0]  ATTR_INI_FWD  = 3'h4;
  localparam logic [2:0]  ATTR_INI_BOTH = 3'h6;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_CMP   = 3'b001,
    ST_DELAY = 3'b010,
    ST_PULSE = 3'b011,
    ST_DONE  = 3'b100
  } pco_state_t;

  // Settings that take effect only when the function is switched on
  typedef struct packed {
    logic [3:0]  res;
    logic        inc;
    logic        cyc;
    logic        pol;
    logic        form;
    logic [15:0] pin;
  } pco_cfg_t;

  localparam pco_cfg_t CFG_RST = '{res: RES_RST, inc: 1'b0, cyc: 1'b0, pol: 1'b0,
                                   form: 1'b0, pin: PIN_RST};

endpackage : pco_pkg

/* verification/pco_out_reader.sv */
// Far-side equipment that reads the compare pin and measures high pulses
`timescale 1ns/100ps
`default_nettype none
module pco_out_reader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_in,
  output int       pulse_count,
  output int       last_width
);
  int run_r;

  // Counts cycles high; a run is booked only when the line falls again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_count <= 0;
      last_width  <= 0;
      run_r       <= 0;
    end else if (line_in === 1'b1) begin
      run_r <= run_r + 1;
    end else begin
      if (run_r != 0) begin
        pulse_count <= pulse_count + 1;
        last_width  <= run_r;
      end
      run_r <= 0;
    end
  end
endmodule : pco_out_reader
`default_nettype wire

/* verification/pco_position_compare_output_props.sv */
// Port-level checker for the position compare output block
`timescale 1ns/100ps
`default_nettype none
module pco_position_compare_output_props #(
  parameter int unsigned CYC_PER_100US = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_out,
  input wire logic [15:0] compare_pin_assign
);
  import pco_pkg::*;
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bus handshakes
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready kept high");
  a_w_refused: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("wready kept high");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid kept high");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept high");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hFFC
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  // Values seen at the first edge after any reset
  a_pin_reset: assert property ($rose(aresetn) |-> compare_pin_assign == PIN_RST)
    else $error("pin code not at default");
  a_out_reset: assert property ($rose(aresetn) |-> !compare_out)
    else $error("output not at rest level");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_pulse: cover property ($rose(compare_out));
endmodule : pco_position_compare_output_props

bind pco_position_compare_output pco_position_compare_output_props #(
  .CYC_PER_100US(CYC_PER_100US)
) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .compare_out(compare_out), .compare_pin_assign(compare_pin_assign)
);
`default_nettype wire

/* verification/pco_position_compare_output_tb_top.sv */
// Self-checking bench for the position compare output block
`timescale 1ns/100ps
`default_nettype none
module pco_position_compare_output_tb_top;
  import pco_pkg::*;
  localparam int unsigned CYC = 4;  // Short 100 us unit keeps pulses brief
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic [1:0]  resp;
  } pco_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] live_position = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        compare_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] compare_pin_assign;
  logic [31:0] rd;
  int          bad_count = 0, n_checks = 0, cycles = 0, p0, pulse_count, last_width;
  pco_row_t rows [15] = '{
    '{1'b0, OFF_RES, 32'h0, 32'h7, RESP_OKAY},
    '{1'b0, OFF_MODE, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, OFF_POL, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, OFF_FORM, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, OFF_WIDTH, 32'h0, 32'h64, RESP_OKAY},
    '{1'b0, OFF_DELAY, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, OFF_ORG, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, OFF_FIRST, 32'h0, 32'h1, RESP_OKAY},
    '{1'b0, OFF_LAST, 32'h0, 32'h8, RESP_OKAY},
    '{1'b0, OFF_PIN, 32'h0, 32'h10, RESP_OKAY},
    '{1'b0, 12'h0C0, 32'h0, 32'h0, RESP_OKAY},
    '{1'b1, OFF_RES, 32'hF, 32'hA, RESP_OKAY},
    '{1'b1, OFF_WIDTH, 32'h0, 32'h1, RESP_OKAY},
    '{1'b1, OFF_DELAY, 32'h12C, 32'hC8, RESP_OKAY},
    '{1'b1, 12'hFFC, 32'h5, 32'h0, RESP_SLVERR}};

  pco_position_compare_output #(.CYC_PER_100US(CYC)) u_pco_position_compare_output (
    .aclk(aclk), .aresetn(aresetn), .live_position(live_position),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .compare_out(compare_out),
    .compare_pin_assign(compare_pin_assign));
  pco_out_reader u_pco_out_reader (.aclk(aclk), .aresetn(aresetn), .line_in(compare_out),
    .pulse_count(pulse_count), .last_width(last_width));

  always #2.5 aclk = ~aclk;

  // Hang guard, far above the run's length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d = 1'b0, w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_d = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!a_d && s_axi_arready) begin
        a_d = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : wreg

  task automatic mv(input logic [31:0] v);
    @(posedge aclk);
    live_position <= v;
  endtask : mv

  // Bounded wait for a pin level, then judged
  task automatic wait_out(input logic v, input int mx, input string nm);
    int k = 0;
    while (compare_out !== v && k < mx) begin
      @(posedge aclk);
      k++;
    end
    chk(nm, {31'h0, v}, {31'h0, compare_out});
  endtask : wait_out

  initial begin
    cyc(5);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].addr, rows[i].wdata, resp);
        chk("bresp", {30'h0, rows[i].resp}, {30'h0, resp});
      end
      axi_rd(rows[i].addr, rd, resp);
      chk("rdata", rows[i].rexp, rd);
      chk("rresp", {30'h0, rows[i].resp}, {30'h0, resp});
    end
    $display("test registers done");
    // Pulse form, single pass, point 1 carries a code that pulse form skips
    wreg(OFF_RES, 32'h0);
    wreg(OFF_WIDTH, 32'h2);
    wreg(OFF_DELAY, 32'h0);
    wreg(OFF_LAST, 32'h3);
    wreg(12'h040, 32'h5);
    wreg(12'h044, 32'h1);
    wreg(12'h0C4, 32'h64);
    wreg(12'h048, 32'h2);
    wreg(12'h0C8, 32'h32);
    wreg(OFF_CTRL, 32'h1);
    cyc(4);
    p0 = pulse_count;
    mv(32'hC8);
    wait_out(1'b1, 4, "forward pulse");
    wait_out(1'b0, 12, "pulse end");
    cyc(2);
    chk("pulse width", 32'(2 * CYC), 32'(last_width));
    mv(32'h0);
    wait_out(1'b1, 4, "backward pulse");
    wait_out(1'b0, 12, "pulse end");
    mv(32'hC8);
    cyc(20);
    chk("single pass", 32'(p0 + 2), 32'(pulse_count));
    $display("test pulse done");
    // Level form with inverted polarity
    wreg(OFF_CTRL, 32'h0);
    wreg(OFF_POL, 32'h1);
    wreg(OFF_FORM, 32'h1);
    wreg(OFF_LAST, 32'h2);
    wreg(12'h040, 32'h1);
    wreg(12'h044, 32'h4);
    wreg(12'h0C0, 32'h64);
    wreg(12'h0C4, 32'h96);
    mv(32'h0);
    wreg(OFF_CTRL, 32'h1);
    cyc(4);
    chk("rest level", 32'h1, {31'h0, compare_out});
    mv(32'h78);
    wait_out(1'b0, 4, "level active");
    cyc(20);
    chk("level held", 32'h0, {31'h0, compare_out});
    mv(32'hC8);
    wait_out(1'b1, 4, "level initial");
    $display("test level done");
    // Cyclic incremental pass, one two-way point, 1 us delay
    wreg(OFF_CTRL, 32'h0);
    wreg(OFF_POL, 32'h0);
    wreg(OFF_FORM, 32'h0);
    wreg(OFF_MODE, 32'h3);
    wreg(OFF_LAST, 32'h1);
    wreg(12'h040, 32'h3);
    wreg(OFF_DELAY, 32'h1);
    mv(32'h0);
    wreg(OFF_CTRL, 32'h1);
    cyc(4);
    mv(32'h96);
    cyc(150);
    chk("delay hold", 32'h0, {31'h0, compare_out});
    wait_out(1'b1, 60, "delayed pulse");
    wait_out(1'b0, 12, "pulse end");
    mv(32'h12C);
    wait_out(1'b1, 215, "cyclic wrap");
    $display("test cyclic done");
    // Origin set with halved resolution, pin code latched on enable
    wreg(OFF_CTRL, 32'h0);
    mv(32'h0);
    wreg(OFF_RES, 32'h1);
    wreg(OFF_ORG, 32'hFFFFFFFB);
    wreg(OFF_PIN, 32'h22);
    wreg(OFF_CTRL, 32'h3);
    axi_rd(OFF_POS, rd, resp);
    chk("origin pos", 32'hFFFFFFFB, rd);
    chk("pin latch", 32'h22, {16'h0, compare_pin_assign});
    mv(32'hA);
    cyc(3);
    axi_rd(OFF_POS, rd, resp);
    chk("scaled pos", 32'h0, rd);
    $display("test origin done");
    // Reset in mid-run restores defaults
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    chk("pin reset", 32'h10, {16'h0, compare_pin_assign});
    chk("out reset", 32'h0, {31'h0, compare_out});
    axi_rd(OFF_RES, rd, resp);
    chk("res reset", 32'h7, rd);
    $display("test reset done");
    final_report();
  end
endmodule : pco_position_compare_output_tb_top
`default_nettype wire
